// file: rtl/alu_unit.sv
`timescale 1ns/10ps
`default_nettype none
module alu_unit
(
  input wire logic [3:0] op_in,
  input wire logic [3:0] a_in,
  input wire logic [3:0] b_in,
  input wire logic cin_in,
  output logic [3:0] res_out,
  output logic cout_out,
  output logic bflag_out,
  output logic carry_wr_out,
  output logic flag_wr_out,
  output logic binary_out
);
  logic [4:0] wide; // result with carry in bit 4

  // a is the top item, b the second item
  always_comb
  begin
    wide = {1'b0, a_in};
    carry_wr_out = 1'b1;
    flag_wr_out = 1'b1;
    binary_out = 1'b0;
    case (op_in)
      4'h0: begin wide = {1'b0, b_in} + {1'b0, a_in}; binary_out = 1'b1; end
      4'h1: begin wide = {1'b0, b_in} + {1'b0, a_in} + {4'h0, cin_in}; binary_out = 1'b1; end
      4'h2: begin wide = {1'b0, b_in} - {1'b0, a_in}; binary_out = 1'b1; end
      4'h3: begin wide = {1'b0, b_in} - {1'b0, a_in} - {4'h0, cin_in}; binary_out = 1'b1; end
      // boolean group keeps the carry flag
      4'h4: begin wide = {1'b0, b_in & a_in}; carry_wr_out = 1'b0; binary_out = 1'b1; end
      4'h5: begin wide = {1'b0, b_in | a_in}; carry_wr_out = 1'b0; binary_out = 1'b1; end
      4'h6: begin wide = {1'b0, b_in ^ a_in}; carry_wr_out = 1'b0; binary_out = 1'b1; end
      4'h7: begin wide = {1'b0, ~a_in}; carry_wr_out = 1'b0; end
      // shifts and rotates move the carry as a fifth bit; C and D increment and decrement the top item
      4'h8: wide = {a_in, 1'b0};
      4'h9: wide = {a_in, cin_in};
      4'hA: wide = {a_in[0], 1'b0, a_in[3:1]};
      4'hB: wide = {a_in[0], cin_in, a_in[3:1]};
      4'hC: wide = {1'b0, a_in} + 5'h01;
      4'hD: wide = {1'b0, a_in} - 5'h01;
      // spare codes pass the top item and touch no flag
      default:
      begin
        carry_wr_out = 1'b0;
        flag_wr_out = 1'b0;
      end
    endcase
    res_out = wide[3:0];
    cout_out = wide[4];
    // branch flag: carry for arithmetic and shifts, zero result for boolean
    bflag_out = carry_wr_out ? wide[4] : (wide[3:0] == 4'h0);
  end
endmodule
`default_nettype wire

// file: rtl/core_cfg.svh
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH
// datapath widths
`define PC_W 12
`define ADDR_W 8
`define NIB_W 4
// reset values
`define PC_RESET 12'h000
`define PTR_RESET 8'h00
`define NIB_RESET 4'h0
`define FLAGS_RESET 4'h0
// return stack slot: pointer steps by four, three nibbles hold an entry
`define RP_STEP 8'h04
// interrupt vectors inside the zero page
`define VEC_STEP 12'h040
`define VEC_TOP 12'h1E0
`define IRQ_LEVELS 8
// condition flag bit positions
`define FLAG_C 0
`define FLAG_B 1
`define FLAG_I 3
// opcode groups, high nibble of the instruction byte
`define GRP_ALU 4'h0
`define GRP_MISC 4'h2
`define GRP_MEM 4'h3
`define GRP_BRANCH 4'h4
`define GRP_JUMP 4'h5
`define GRP_CALL 4'h6
`define GRP_LDPTR 4'h7
`define GRP_LIT 4'h8
`define GRP_IN 4'h9
`define GRP_OUT 4'hA
// miscellaneous operations, low nibble
`define OP_DROP 4'h0
`define OP_DUP 4'h1
`define OP_SET_BC 4'h2
`define OP_TOG_B 4'h3
`define OP_FLAG_ST 4'h4
`define OP_FLAG_LD 4'h5
`define OP_INT_OFF 4'h6
`define OP_INT_ON 4'h7
`define OP_SLEEP 4'h8
`define OP_RET 4'h9
`define OP_RTI 4'hA
`define OP_TABLE 4'hB
// memory operation modes, bits 3:2 of the low nibble
`define MODE_PREINC 2'h1
`define MODE_POSTDEC 2'h2
`endif

// file: rtl/core_pkg.sv
package core_pkg;
  // sequencer states, one step per machine cycle
  typedef enum logic [2:0] {st_fill, st_exec, st_rpush, st_rpop, st_tab_hi, st_tab_lo, st_mem2} core_state_e;
  typedef logic [11:0] pc_t;
  typedef logic [7:0] ram_addr_t;
  typedef logic [3:0] nibble_t;
endpackage

// file: rtl/nibble_ram.sv
`timescale 1ns/10ps
`default_nettype none
module nibble_ram #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 4
)
(
  input wire logic mclk_in,
  input wire logic ce_in,
  ram_port_if.mem port
);
  // storage array, no reset: contents are undefined until written
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] rdata_r; // read data register

  // write then read; read returns the old word on a same-cycle write
  always_ff @(posedge mclk_in)
  begin
    if (ce_in)
    begin
      if (port.we)
      begin
        mem[port.addr] <= port.wdata;
      end
      rdata_r <= mem[port.addr];
    end
  end

  assign port.rdata = rdata_r;
endmodule
`default_nettype wire

// file: rtl/ram_port_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ram_port_if;
  import core_pkg::*;
  ram_addr_t addr; // nibble address
  nibble_t wdata; // write data
  logic we; // write strobe, one clock
  nibble_t rdata; // registered read data
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// file: rtl/stack_cpu_core_datapath.sv
`timescale 1ns/10ps
`default_nettype none
`include "core_cfg.svh"
module stack_cpu_core_datapath
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [7:0] rom_data_in,
  output var core_pkg::pc_t rom_addr_out,
  input wire logic [7:0] irq_in,
  output var logic irq_ack_out,
  output var logic [2:0] irq_level_out,
  output var logic irq_return_out,
  input wire core_pkg::nibble_t io_data_in,
  output var core_pkg::nibble_t io_addr_out,
  output var core_pkg::nibble_t io_data_out,
  output var logic io_rd_out,
  output var logic io_wr_out,
  output var logic sleep_out,
  output var logic int_enable_out
);
  import core_pkg::*;

  // highest pending level wins
  function automatic logic [2:0] top_request(input logic [7:0] req);
    top_request = 3'h0;
    for (int i = 0; i < `IRQ_LEVELS; i++)
    begin
      if (req[i])
        top_request = 3'(i);
    end
  endfunction

  // levels 0 to 6 sit n+1 steps up and level 7 at 1E0, so level 0 stays clear of the reset entry at 000
  function automatic pc_t irq_vector(input logic [2:0] lvl);
    if (lvl == 3'h7)
      irq_vector = `VEC_TOP;
    else
      irq_vector = `VEC_STEP * ({9'h000, lvl} + 12'h001);
  endfunction

  core_state_e state_r, state_nxt; // sequencer
  logic phase_r, phase_nxt; // second clock of a machine cycle
  logic [1:0] cnt_r, cnt_nxt; // nibble step inside a multi-cycle op
  pc_t pc_r, pc_nxt; // program counter
  logic [7:0] ir_r, ir_nxt; // prefetched instruction
  ram_addr_t sp_r, sp_nxt; // expression stack pointer
  ram_addr_t rp_r, rp_nxt; // return stack pointer
  ram_addr_t xa_r, xa_nxt; // ram pointer a
  ram_addr_t yb_r, yb_nxt; // ram pointer b
  nibble_t tos_r, tos_nxt; // accumulator top
  nibble_t flags_r, flags_nxt; // condition flags
  pc_t ret_r, ret_nxt; // return address being stacked or unstacked
  logic [7:0] tmp_r, tmp_nxt; // table byte or fetched nibble
  logic ack_r, ack_nxt;
  logic [2:0] lvl_r, lvl_nxt;
  logic rti_r, rti_nxt;
  logic sleep_r, sleep_nxt;

  logic commit; // last clock of a machine cycle
  logic take_irq; // interrupt entry instead of the prefetched op
  logic [3:0] grp, lo; // opcode fields
  pc_t pc_inc;
  ram_addr_t ram_addr, ptr, eff;
  nibble_t ram_wdata, push_val, pop_val;
  logic wr_req, do_push, do_pop, do_adv, do_rcall;
  pc_t call_target, ret_val;
  logic [3:0] alu_res;
  logic alu_cout, alu_bflag, alu_cwr, alu_fwr, alu_bin;

  ram_port_if ram ();

  nibble_ram #(.ADDR_W(`ADDR_W), .DATA_W(`NIB_W)) u_ram
  (
    .mclk_in(mclk_in),
    .ce_in(ce_in),
    .port(ram.mem)
  );

  // operands are the top register and the second item read at sp
  alu_unit u_alu
  (
    .op_in(lo),
    .a_in(tos_r),
    .b_in(ram.rdata),
    .cin_in(flags_r[`FLAG_C]),
    .res_out(alu_res),
    .cout_out(alu_cout),
    .bflag_out(alu_bflag),
    .carry_wr_out(alu_cwr),
    .flag_wr_out(alu_fwr),
    .binary_out(alu_bin)
  );

  assign commit = ce_in & phase_r;
  assign grp = ir_r[7:4];
  assign lo = ir_r[3:0];
  assign pc_inc = pc_r + 12'h001;
  assign take_irq = (state_r == st_exec) && flags_r[`FLAG_I] && (|irq_in);
  // address stays put for both clocks, so read data is valid on the second
  assign ram.addr = ram_addr;
  assign ram.wdata = ram_wdata;
  assign ram.we = wr_req & commit;

  // next-state and datapath decode
  always_comb
  begin
    state_nxt = state_r;
    phase_nxt = ~phase_r;
    cnt_nxt = cnt_r;
    pc_nxt = pc_r;
    ir_nxt = ir_r;
    sp_nxt = sp_r;
    rp_nxt = rp_r;
    xa_nxt = xa_r;
    yb_nxt = yb_r;
    tos_nxt = tos_r;
    flags_nxt = flags_r;
    ret_nxt = ret_r;
    tmp_nxt = tmp_r;
    lvl_nxt = lvl_r;
    ack_nxt = 1'b0;
    rti_nxt = 1'b0;
    sleep_nxt = 1'b0;
    rom_addr_out = pc_r;
    ram_addr = sp_r;
    ram_wdata = tos_r;
    wr_req = 1'b0;
    io_rd_out = 1'b0;
    io_wr_out = 1'b0;
    do_push = 1'b0;
    do_pop = 1'b0;
    do_adv = 1'b0;
    do_rcall = 1'b0;
    push_val = tos_r;
    pop_val = ram.rdata;
    call_target = pc_r;
    ret_val = pc_r;
    ptr = lo[0] ? yb_r : xa_r;
    eff = (lo[3:2] == `MODE_PREINC) ? ptr + 8'h01 : ptr;
    case (state_r)
      // refill the prefetch after a counter load
      st_fill:
      begin
        do_adv = 1'b1;
        state_nxt = st_exec;
      end
      st_exec:
      begin
        if (take_irq)
        begin
          // short call to the vector; the prefetched op is replayed later
          lvl_nxt = top_request(irq_in);
          ack_nxt = commit;
          call_target = irq_vector(top_request(irq_in));
          ret_val = pc_r - 12'h001;
          do_rcall = 1'b1;
        end
        else if (ir_r[7:6] == 2'b11)
        begin
          // one-byte call into the zero page
          call_target = {3'h0, ir_r[5:0], 3'h0};
          do_rcall = 1'b1;
        end
        else
        begin
          case (grp)
            `GRP_ALU:
            begin
              do_adv = 1'b1;
              tos_nxt = alu_res;
              do_pop = alu_bin;
              pop_val = alu_res;
              if (alu_cwr)
                flags_nxt[`FLAG_C] = alu_cout;
              if (alu_fwr)
                flags_nxt[`FLAG_B] = alu_bflag;
            end
            `GRP_MISC:
            begin
              do_adv = 1'b1;
              case (lo)
                `OP_DROP: do_pop = 1'b1;
                `OP_DUP: do_push = 1'b1;
                `OP_SET_BC: flags_nxt[`FLAG_B:`FLAG_C] = 2'b11;
                `OP_TOG_B: flags_nxt[`FLAG_B] = ~flags_r[`FLAG_B];
                `OP_FLAG_ST:
                begin
                  flags_nxt = tos_r;
                  do_pop = 1'b1;
                end
                `OP_FLAG_LD:
                begin
                  do_push = 1'b1;
                  push_val = flags_r;
                end
                `OP_INT_OFF: flags_nxt[`FLAG_I] = 1'b0;
                `OP_INT_ON: flags_nxt[`FLAG_I] = 1'b1;
                `OP_SLEEP:
                begin
                  flags_nxt[`FLAG_I] = 1'b1;
                  sleep_nxt = commit;
                end
                `OP_RET, `OP_RTI:
                begin
                  // first nibble of the entry; pointer drops after the last
                  do_adv = 1'b0;
                  ram_addr = rp_r + 8'h01;
                  ret_nxt = {ram.rdata, ret_r[7:0]};
                  rti_nxt = commit && (lo == `OP_RTI);
                  cnt_nxt = 2'h1;
                  state_nxt = st_rpop;
                end
                `OP_TABLE:
                begin
                  // counter path fetches the constant, prefetch waits
                  do_adv = 1'b0;
                  rom_addr_out = {xa_r, tos_r};
                  tmp_nxt = rom_data_in;
                  state_nxt = st_tab_hi;
                end
                default: ;
              endcase
            end
            `GRP_MEM:
            begin
              // first cycle touches the pointed nibble, second the stack
              ram_addr = eff;
              if (lo[3:2] != `MODE_PREINC && lo[3:2] != `MODE_POSTDEC)
                ptr = eff;
              else if (lo[3:2] == `MODE_PREINC)
                ptr = eff;
              else
                ptr = eff - 8'h01;
              if (lo[0])
                yb_nxt = ptr;
              else
                xa_nxt = ptr;
              wr_req = lo[1];
              tmp_nxt = {4'h0, ram.rdata};
              state_nxt = st_mem2;
            end
            `GRP_BRANCH, `GRP_JUMP:
            begin
              // second byte is the word being prefetched now
              if (grp == `GRP_JUMP || flags_r[`FLAG_B])
                pc_nxt = {lo, rom_data_in};
              else
                pc_nxt = pc_inc;
              state_nxt = st_fill;
            end
            `GRP_CALL:
            begin
              call_target = {lo, rom_data_in};
              ret_val = pc_inc;
              do_rcall = 1'b1;
            end
            `GRP_LDPTR:
            begin
              // software sets up both stacks with this after reset
              case (lo[1:0])
                2'h0: sp_nxt = rom_data_in;
                2'h1: rp_nxt = rom_data_in;
                2'h2: xa_nxt = rom_data_in;
                default: yb_nxt = rom_data_in;
              endcase
              pc_nxt = pc_inc;
              state_nxt = st_fill;
            end
            `GRP_LIT:
            begin
              do_adv = 1'b1;
              do_push = 1'b1;
              push_val = lo;
            end
            `GRP_IN:
            begin
              do_adv = 1'b1;
              do_push = 1'b1;
              push_val = io_data_in;
              io_rd_out = commit;
            end
            `GRP_OUT:
            begin
              do_adv = 1'b1;
              do_pop = 1'b1;
              io_wr_out = commit;
            end
            default: do_adv = 1'b1;
          endcase
        end
      end
      // remaining two nibbles of a return entry, slot offset 0 unwritten
      st_rpush:
      begin
        ram_addr = rp_r + {6'h00, cnt_r} + 8'h01;
        ram_wdata = (cnt_r == 2'h1) ? ret_r[7:4] : ret_r[3:0];
        wr_req = 1'b1;
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == 2'h2)
          state_nxt = st_fill;
      end
      st_rpop:
      begin
        ram_addr = rp_r + {6'h00, cnt_r} + 8'h01;
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == 2'h1)
          ret_nxt = {ret_r[11:8], ram.rdata, ret_r[3:0]};
        else
        begin
          pc_nxt = {ret_r[11:4], ram.rdata};
          rp_nxt = rp_r - `RP_STEP;
          state_nxt = st_fill;
        end
      end
      st_tab_hi:
      begin
        do_push = 1'b1;
        push_val = tmp_r[7:4];
        state_nxt = st_tab_lo;
      end
      st_tab_lo:
      begin
        do_push = 1'b1;
        push_val = tmp_r[3:0];
        do_adv = 1'b1;
        state_nxt = st_exec;
      end
      st_mem2:
      begin
        do_adv = 1'b1;
        do_pop = lo[1];
        do_push = ~lo[1];
        push_val = tmp_r[3:0];
        state_nxt = st_exec;
      end
      default: state_nxt = st_fill;
    endcase
    // push: pre-increment, old top goes under the new one
    if (do_push)
    begin
      sp_nxt = sp_r + 8'h01;
      ram_addr = sp_nxt;
      ram_wdata = tos_r;
      wr_req = 1'b1;
      tos_nxt = push_val;
    end
    // pop: second item to the top register, then decrement
    if (do_pop)
    begin
      tos_nxt = pop_val;
      sp_nxt = sp_r - 8'h01;
    end
    // first nibble of a return entry goes out with the counter load
    if (do_rcall)
    begin
      ret_nxt = ret_val;
      rp_nxt = rp_r + `RP_STEP;
      ram_addr = rp_nxt + 8'h01;
      ram_wdata = ret_val[11:8];
      wr_req = 1'b1;
      pc_nxt = call_target;
      cnt_nxt = 2'h1;
      state_nxt = st_rpush;
    end
    // prefetch: next byte is taken while data is being accessed
    if (do_adv)
    begin
      ir_nxt = rom_data_in;
      pc_nxt = pc_inc;
    end
  end

  // state registers; machine state moves only on the second clock
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      phase_r <= 1'b0;
      state_r <= st_fill;
      cnt_r <= 2'h0;
      pc_r <= `PC_RESET;
      ir_r <= 8'h00;
      sp_r <= `PTR_RESET;
      rp_r <= `PTR_RESET;
      xa_r <= `PTR_RESET;
      yb_r <= `PTR_RESET;
      tos_r <= `NIB_RESET;
      flags_r <= `FLAGS_RESET;
      ret_r <= `PC_RESET;
      tmp_r <= 8'h00;
      lvl_r <= 3'h0;
      ack_r <= 1'b0;
      rti_r <= 1'b0;
      sleep_r <= 1'b0;
    end
    else if (ce_in)
    begin
      phase_r <= phase_nxt;
      ack_r <= ack_nxt;
      rti_r <= rti_nxt;
      sleep_r <= sleep_nxt;
      if (phase_r)
      begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        pc_r <= pc_nxt;
        ir_r <= ir_nxt;
        sp_r <= sp_nxt;
        rp_r <= rp_nxt;
        xa_r <= xa_nxt;
        yb_r <= yb_nxt;
        tos_r <= tos_nxt;
        flags_r <= flags_nxt;
        ret_r <= ret_nxt;
        tmp_r <= tmp_nxt;
        lvl_r <= lvl_nxt;
      end
    end
  end

  assign irq_ack_out = ack_r;
  assign irq_level_out = lvl_r;
  assign irq_return_out = rti_r;
  assign sleep_out = sleep_r;
  assign int_enable_out = flags_r[`FLAG_I];
  assign io_addr_out = lo;
  assign io_data_out = tos_r;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  wire exec_now = commit && (state_r == st_exec) && !take_irq;

  sequence s_irq_taken;
    commit && take_irq;
  endsequence
  sequence s_irq_entered;
    (state_r == st_rpush) && irq_ack_out && (ret_r == $past(pc_r) - 12'h001);
  endsequence

  chk_state_two_clk: assert property ((state_r != $past(state_r)) |-> $past(phase_r))
    else $error("state moved off a machine cycle boundary");
  chk_seq_pc_step: assert property (exec_now && grp == `GRP_ALU |=> pc_r == $past(pc_inc))
    else $error("sequential counter step wrong");
  chk_push_ptr: assert property (exec_now && grp == `GRP_LIT |=> sp_r == $past(sp_r) + 8'h01 && tos_r == $past(lo))
    else $error("push did not pre-increment");
  chk_pop_copy: assert property (exec_now && grp == `GRP_MISC && lo == `OP_DROP
    |=> tos_r == $past(ram.rdata) && sp_r == $past(sp_r) - 8'h01)
    else $error("pop did not copy second item");
  chk_rp_step: assert property (commit && do_rcall |=> rp_r == $past(rp_r) + `RP_STEP ##2 state_r == st_rpush)
    else $error("return pointer step wrong");
  chk_irq_gate: assert property (irq_ack_out |-> $past(flags_r[`FLAG_I]))
    else $error("interrupt entered while disabled");
  chk_irq_entry: assert property (s_irq_taken |=> s_irq_entered ##0 pc_r == irq_vector(top_request($past(irq_in))))
    else $error("interrupt entry wrong");
  chk_int_off: assert property (exec_now && grp == `GRP_MISC && lo == `OP_INT_OFF |=> !int_enable_out)
    else $error("disable did not clear enable");
  chk_branch_gate: assert property (exec_now && grp == `GRP_BRANCH && !flags_r[`FLAG_B]
    |=> pc_r == $past(pc_inc) && state_r == st_fill)
    else $error("branch taken without branch flag");
  chk_bool_carry: assert property (exec_now && grp == `GRP_ALU && lo inside {4'h4, 4'h5, 4'h6}
    |=> $stable(flags_r[`FLAG_C]))
    else $error("boolean op touched carry");
endmodule
`default_nettype wire

// file: testbench/rom_io_model.sv
`timescale 1ns/10ps
`default_nettype none
// program memory and peripheral stand-in on the far side of the core
module rom_io_model
(
  input wire logic mclk_in,
  input wire core_pkg::pc_t rom_addr_in,
  output var logic [7:0] rom_data_out,
  input wire core_pkg::nibble_t io_addr_in,
  input wire logic io_rd_in,
  output var core_pkg::nibble_t io_data_out
);
  import core_pkg::*;
  logic [7:0] mem [0:4095]; // program image, filled by the bench
  nibble_t junk_r = 4'h0; // wandering level on an idle read bus
  // async rom: answers within the machine cycle
  assign rom_data_out = mem[rom_addr_in];
  // peripheral drives only during a read strobe, so stale data never passes for a match
  assign io_data_out = io_rd_in ? (io_addr_in ^ 4'hA) : junk_r;
  // idle pattern changes every clock
  always @(posedge mclk_in)
    junk_r <= ~junk_r + 4'h3;
endmodule
`default_nettype wire

// file: testbench/stack_cpu_core_datapath_tb.sv
`timescale 1ns/10ps
`default_nettype none
module stack_cpu_core_datapath_tb;
  import core_pkg::*;
  logic mclk_in = 1'b0; // 40 MHz
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [31:0] ce_mask = 32'hFFFF_FFFF; // enable per clock, random once seeded
  logic [4:0] ce_k = 5'h00; // position in the enable mask
  logic [7:0] irq_in = 8'h00;
  pc_t rom_addr;
  logic [7:0] rom_data;
  nibble_t io_data_in, io_addr, io_data;
  logic irq_ack, irq_ret, io_rd, io_wr, sleep_p, int_en;
  logic [2:0] irq_lvl;
  int n_fail = 0;
  int n_tests = 0;
  int acks = 0; // interrupt entries seen
  int rets = 0; // interrupt returns seen
  logic woke = 1'b0; // sleep pulse seen, enable set
  logic [7:0] exp_q [$]; // expected {port, data} of each write
  pc_t pc = 12'h000; // program build pointer
  logic [7:0] r [0:6]; // random operands
  int i;
  stack_cpu_core_datapath DUT (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce_in), .rom_data_in(rom_data),
    .rom_addr_out(rom_addr), .irq_in(irq_in), .irq_ack_out(irq_ack), .irq_level_out(irq_lvl),
    .irq_return_out(irq_ret), .io_data_in(io_data_in), .io_addr_out(io_addr), .io_data_out(io_data),
    .io_rd_out(io_rd), .io_wr_out(io_wr), .sleep_out(sleep_p), .int_enable_out(int_en));
  rom_io_model rom (.mclk_in(mclk_in), .rom_addr_in(rom_addr), .rom_data_out(rom_data),
    .io_addr_in(io_addr), .io_rd_in(io_rd), .io_data_out(io_data_in));
  always #12.5 mclk_in = ~mclk_in;
  // random clock-enable stalls, so frozen machine cycles get exercised
  always @(posedge mclk_in)
  begin
    #2 ce_in = ce_mask[ce_k];
    ce_k = ce_k + 5'h01;
  end
  task automatic wrap_up;
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  // one program byte, placed before reset release
  task automatic put(input logic [7:0] b);
    rom.mem[pc] = b;
    pc++;
  endtask
  task automatic lit(input nibble_t v);
    put({4'h8, v});
  endtask
  // write to a port, noting the value it must carry
  task automatic emit_out(input nibble_t p, input nibble_t v);
    put({4'hA, p});
    exp_q.push_back({p, v});
  endtask
  // conditional branch over the next two bytes
  task automatic branch_fwd;
    pc_t t;
    put(8'h40);
    t = pc + 12'h003;
    put(t[7:0]);
  endtask
  // bounded wait on an event counter
  task automatic settle(ref int cnt);
    for (int k = 0; k < 4000 && cnt == 0; k++)
      @(posedge mclk_in);
    if (cnt == 0)
    begin
      n_fail++;
      wrap_up();
    end
  endtask
  // write monitor: oldest note against each strobe
  always @(posedge mclk_in)
    if (io_wr === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        n_fail++;
        $display("unexpected surplus write exp none got %h", {io_addr, io_data});
      end
      else
        chk("io write", exp_q.pop_front(), {io_addr, io_data});
    end
  // interrupt monitor
  always @(posedge mclk_in)
  begin
    if (sleep_p === 1'b1)
      woke <= 1'b1;
    if (irq_ret === 1'b1)
      rets++;
    if (irq_ack === 1'b1)
    begin
      acks++;
      chk("irq level", 8'h05, {5'h00, irq_lvl});
      chk("masked entry", 8'h01, {7'h00, woke});
    end
  end
  initial
  begin
    for (i = 0; i < 4096; i++)
      rom.mem[i] = 8'hB0;
    i = $urandom(32'h3E4F);
    for (i = 0; i < 7; i++)
      r[i] = 8'($urandom());
    ce_mask = $urandom() | 32'h5555_5555;
    put(8'h70);
    put(8'h80);
    put(8'h71);
    put(8'hFC);
    lit(r[0][3:0]);
    lit(r[1][3:0]);
    put(8'h00);
    emit_out(4'h1, r[0][3:0] + r[1][3:0]);
    lit(r[2][3:0]);
    lit(r[3][3:0]);
    put(8'h04);
    emit_out(4'h2, r[2][3:0] & r[3][3:0]);
    put(8'h25);
    emit_out(4'h3, {2'b00, (r[2][3:0] & r[3][3:0]) == 4'h0, 5'(r[0][3:0]) + 5'(r[1][3:0]) > 5'd15});
    lit(r[0][3:0]);
    lit(r[1][3:0]);
    put(8'h02);
    emit_out(4'h1, r[0][3:0] - r[1][3:0]);
    put(8'h93);
    emit_out(4'h4, 4'h9);
    put(8'h73);
    put(8'h40);
    lit(r[4][3:0]);
    put(8'h33);
    lit(r[5][3:0]);
    put(8'h37);
    put(8'h39);
    put(8'h31);
    emit_out(4'h5, r[4][3:0]);
    emit_out(4'h5, r[5][3:0]);
    put(8'h72);
    put(8'h20);
    lit(4'h5);
    put(8'h2B);
    lit(4'h3);
    put(8'h20);
    rom.mem[12'h205] = r[6];
    emit_out(4'h6, r[6][3:0]);
    emit_out(4'h6, r[6][7:4]);
    put(8'hFF);
    rom.mem[12'h1F8] = 8'h86;
    rom.mem[12'h1F9] = 8'hA7;
    rom.mem[12'h1FA] = 8'h29;
    exp_q.push_back(8'h76);
    put(8'h22);
    branch_fwd();
    lit(4'hE);
    put(8'hA5);
    put(8'h23);
    branch_fwd();
    lit(4'hD);
    emit_out(4'h5, 4'hD);
    put(8'h28);
    put(8'h50);
    put(pc[7:0] - 8'h01);
    rom.mem[12'h180] = 8'h8C;
    rom.mem[12'h181] = 8'hA1;
    rom.mem[12'h182] = 8'h26;
    rom.mem[12'h183] = 8'h2A;
    exp_q.push_back(8'h1C);
    repeat (16) @(posedge mclk_in);
    #2 srst_in = 1'b0;
    irq_in = 8'h24;
    settle(acks);
    @(posedge mclk_in);
    #2 irq_in = 8'h00;
    settle(rets);
    repeat (8) @(posedge mclk_in);
    chk("int enable", 8'h00, {7'h00, int_en});
    chk("pending writes", 8'h00, 8'(exp_q.size()));
    wrap_up();
  end
endmodule
`default_nettype wire
